// ### vss_pkg.sv
package vss_pkg;

  // ****************************************
  // Packet header layout
  // ****************************************
  localparam int          TYPE_MSB        = 31;
  localparam int          TYPE_LSB        = 29;
  localparam int          SUBTYPE_MSB     = 28;
  localparam int          SUBTYPE_LSB     = 27;
  localparam int          OPCODE_MSB      = 26;
  localparam int          OPCODE_LSB      = 24;
  localparam int          SUBOP_MSB       = 23;
  localparam int          SUBOP_LSB       = 16;
  localparam int          LEN_MSB         = 7;
  localparam int          LEN_LSB         = 0;
  localparam logic [2:0]  PIPE_CMD_CLASS  = 3'h3;
  localparam logic [1:0]  PIPE_3D_SUB     = 2'h3;
  localparam logic [2:0]  PIPELINED_OP    = 3'h0;
  localparam logic [7:0]  VSTAGE_SUBOP    = 8'h10;
  localparam logic [7:0]  DEFAULT_LEN     = 8'h04;
  localparam logic [7:0]  LENGTH_BIAS     = 8'h02;

  // ****************************************
  // Body dword layout
  // ****************************************
  localparam logic [7:0]  KERNEL_DW       = 8'h01;
  localparam logic [7:0]  DISPATCH_DW     = 8'h02;
  localparam int          KERNEL_MSB      = 31;
  localparam int          KERNEL_LSB      = 6;
  localparam int          SINGLE_BIT      = 31;
  localparam int          MASKSEL_BIT     = 30;
  localparam int          SAMPLER_MSB     = 29;
  localparam int          SAMPLER_LSB     = 27;
  localparam int          REUSE_BIT       = 1;
  localparam int          SHADER_BIT      = 0;

  // ****************************************
  // Vertex cache and reset values
  // ****************************************
  localparam int          CACHE_DEPTH     = 4;
  localparam int          PTR_W           = 2;
  localparam logic [25:0] KERNEL_RST      = 26'h0000000;
  localparam logic [2:0]  SAMPLER_RST     = 3'h0;

  // ****************************************
  // Controller register map (byte offsets)
  // ****************************************
  localparam logic [3:0]  REG_KERNEL      = 4'h0;
  localparam logic [3:0]  REG_DISPATCH    = 4'h4;
  localparam logic [3:0]  REG_CONTROL     = 4'h8;
  localparam logic [3:0]  REG_GO          = 4'hC;
  localparam int          GO_BIT          = 0;
  localparam int          BUSY_BIT        = 0;
  localparam logic [2:0]  PKT_LAST        = 3'h5;

  typedef logic [31:0] dword_t;
  typedef logic [15:0] vidx_t;

  typedef enum logic [1:0]
  {
    DEC_HDR  = 2'b00,
    DEC_BODY = 2'b01,
    DEC_SKIP = 2'b10
  } dec_state_t;

  typedef enum logic [0:0]
  {
    FEED_IDLE = 1'b0,
    FEED_SEND = 1'b1
  } feed_state_t;

endpackage

// ### vertex_stage_if.sv
`timescale 1ns/1ps
`default_nettype none

interface vertex_stage_if;
  logic          dwValid;
  vss_pkg::dword_t dwData;
  logic          dwReady;

  modport device
  (
    input  dwValid,
    input  dwData,
    output dwReady
  );

  modport host
  (
    output dwValid,
    output dwData,
    input  dwReady
  );
endinterface

`default_nettype wire

// ### vertex_stage_decode.sv
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Reuse 0, shading on: every vertex shaded
// - Reuse 1, shading on: only misses shaded
// - Reuse on, shading off: misses stored, unshaded
// - Invalidate cache on disable, toggle, boundaries
// - Shading off: vertices forwarded unmodified
// - Last dword bits 1:0 always honoured
// - Header type 3h, subtype 3h matched
// - Opcode 0h, sub-opcode 10h matched
// - Length field gives dwords minus two
// - Dword 1 bits 31:6 kernel start
// - Kernel pointer, samplers ignored when off
// - Dword 2 bit 31 forces single vertex
// - Dword 2 bit 30 picks mask source
// - One-flow flag picks init or exec
// - Dword 2 bits 29:27 sampler groups
// - Sampler count only sets prefetch
module vertex_stage_decode
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  vertex_stage_if.device     link,
  input  wire logic          drawBoundary,
  input  wire logic          instanceBoundary,
  input  wire logic          oneFlowFlag,
  input  wire logic          vtxValid,
  input  wire vss_pkg::vidx_t vtxIndex,
  output logic [25:0]        kernelStart,
  output logic               singleVertex,
  output logic               maskSourceSelect,
  output logic [2:0]         samplerPrefetch,
  output logic               shaderStageOn,
  output logic               vertexReuseOff,
  output logic               initMaskVector,
  output logic               execMaskVector,
  output logic               stateApplied,
  output logic               headerError,
  output logic               shadeValid,
  output logic               storeValid,
  output logic               passValid,
  output logic               hitValid,
  output vss_pkg::vidx_t     vtxIndexOut
);
  import vss_pkg::*;

  // ****************************************
  // Packet decode
  // ****************************************
  dec_state_t  state_q, state_d;
  logic [7:0]  idx_q, idx_d;
  logic [7:0]  last_q, last_d;
  logic [25:0] kernelPend_q, kernelPend_d;
  logic [1:0]  dispPend_q, dispPend_d;
  logic [2:0]  samplerPend_q, samplerPend_d;
  logic [25:0] kernel_q, kernel_d;
  logic [2:0]  sampler_q, sampler_d;
  logic        single_q, single_d, maskSel_q, maskSel_d;
  logic        shader_q, shader_d, reuse_q, reuse_d;
  logic        applied_q, applied_d, hdrErr_q, hdrErr_d;
  logic        ready_q, take, hdrMatch;

  assign take = link.dwValid && ready_q;
  assign hdrMatch = (link.dwData[TYPE_MSB:TYPE_LSB] == PIPE_CMD_CLASS)
                 && (link.dwData[SUBTYPE_MSB:SUBTYPE_LSB] == PIPE_3D_SUB)
                 && (link.dwData[OPCODE_MSB:OPCODE_LSB] == PIPELINED_OP)
                 && (link.dwData[SUBOP_MSB:SUBOP_LSB] == VSTAGE_SUBOP);

  always_comb
  begin
    state_d      = state_q;
    idx_d        = idx_q;
    last_d       = last_q;
    kernelPend_d = kernelPend_q;
    dispPend_d   = dispPend_q;
    kernel_d     = kernel_q;
    single_d     = single_q;
    maskSel_d    = maskSel_q;
    sampler_d    = sampler_q;
    shader_d     = shader_q;
    reuse_d      = reuse_q;
    applied_d    = 1'b0;
    hdrErr_d     = 1'b0;
    samplerPend_d = samplerPend_q;
    if (take)
      idx_d = idx_q + 8'h01;
    case (state_q)
      DEC_HDR:
      begin
        if (take)
        begin
          idx_d  = 8'h01;
          // Dwords after the header equal length field plus one
          last_d = link.dwData[LEN_MSB:LEN_LSB] + LENGTH_BIAS - 8'h01;
          if (hdrMatch)
            state_d = DEC_BODY;
          else
            state_d = DEC_SKIP;
          hdrErr_d = !hdrMatch;
        end
      end
      DEC_BODY:
      begin
        if (take && (idx_q == KERNEL_DW))
          kernelPend_d = link.dwData[KERNEL_MSB:KERNEL_LSB];
        if (take && (idx_q == DISPATCH_DW))
        begin
          dispPend_d    = {link.dwData[SINGLE_BIT], link.dwData[MASKSEL_BIT]};
          samplerPend_d = link.dwData[SAMPLER_MSB:SAMPLER_LSB];
        end
        if (take && (idx_q == last_q))
        begin
          // Everything lands in one cycle, so no half-updated state is seen
          shader_d  = link.dwData[SHADER_BIT];
          reuse_d   = link.dwData[REUSE_BIT];
          single_d  = dispPend_q[1];
          maskSel_d = dispPend_q[0];
          kernel_d  = link.dwData[SHADER_BIT] ? kernelPend_q : KERNEL_RST;
          sampler_d = link.dwData[SHADER_BIT] ? samplerPend_q : SAMPLER_RST;
          applied_d = 1'b1;
          state_d   = DEC_HDR;
        end
      end
      DEC_SKIP:
        if (take && (idx_q == last_q))
          state_d = DEC_HDR;
      default:
        state_d = DEC_HDR;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q       <= DEC_HDR;
      idx_q         <= 8'h00;
      last_q        <= 8'h00;
      kernelPend_q  <= KERNEL_RST;
      dispPend_q    <= 2'h0;
      samplerPend_q <= SAMPLER_RST;
      kernel_q      <= KERNEL_RST;
      single_q      <= 1'b0;
      maskSel_q     <= 1'b0;
      sampler_q     <= SAMPLER_RST;
      shader_q      <= 1'b0;
      reuse_q       <= 1'b0;
      applied_q     <= 1'b0;
      hdrErr_q      <= 1'b0;
      ready_q       <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      idx_q         <= idx_d;
      last_q        <= last_d;
      kernelPend_q  <= kernelPend_d;
      dispPend_q    <= dispPend_d;
      samplerPend_q <= samplerPend_d;
      kernel_q      <= kernel_d;
      single_q      <= single_d;
      maskSel_q     <= maskSel_d;
      sampler_q     <= sampler_d;
      shader_q      <= shader_d;
      reuse_q       <= reuse_d;
      applied_q     <= applied_d;
      hdrErr_q      <= hdrErr_d;
      ready_q       <= 1'b1;
    end
  end

  assign link.dwReady = ready_q;

  // ****************************************
  // Vertex cache and routing
  // ****************************************
  logic [CACHE_DEPTH-1:0] tagValid_q, tagValid_d;
  vidx_t                  tag_q [CACHE_DEPTH], tag_d [CACHE_DEPTH];
  logic [PTR_W-1:0]       fill_q, fill_d;
  logic [CACHE_DEPTH-1:0] hitVec;
  logic                   hit, flush;
  // Route bits, high to low: shade, store, pass, hit
  logic [3:0]             route_q, route_d;
  vidx_t                  vOut_q;
  logic                   initMask_q, execMask_q;

  for (genvar g = 0; g < CACHE_DEPTH; g++)
  begin : gLookup
    assign hitVec[g] = tagValid_q[g] && (tag_q[g] == vtxIndex);
  end

  // Lookups during a flush cycle count as misses and are not kept
  assign hit   = (|hitVec) && reuse_q && !flush;
  assign flush = drawBoundary || instanceBoundary
              || (reuse_q && !reuse_d)
              || (shader_q != shader_d);

  always_comb
  begin
    tagValid_d = tagValid_q;
    tag_d      = tag_q;
    fill_d     = fill_q;
    route_d    = 4'h0;
    if (vtxValid && !reuse_q)
      route_d = {shader_q, 1'b0, !shader_q, 1'b0};
    else if (vtxValid && hit)
      route_d = {2'b00, !shader_q, 1'b1};
    else if (vtxValid)
    begin
      route_d = {shader_q, !shader_q, !shader_q, 1'b0};
      if (!flush)
      begin
        tag_d[fill_q]      = vtxIndex;
        tagValid_d[fill_q] = 1'b1;
        fill_d             = fill_q + 1'b1;
      end
    end
    if (flush)
      tagValid_d = '0;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tagValid_q <= '0;
      tag_q      <= '{default: 16'h0000};
      fill_q     <= '0;
      route_q    <= 4'h0;
      vOut_q     <= 16'h0000;
      initMask_q <= 1'b0;
      execMask_q <= 1'b0;
    end
    else
    begin
      tagValid_q <= tagValid_d;
      tag_q      <= tag_d;
      fill_q     <= fill_d;
      route_q    <= route_d;
      vOut_q     <= vtxIndex;
      initMask_q <= !oneFlowFlag && maskSel_d;
      execMask_q <= oneFlowFlag && maskSel_d;
    end
  end

  assign kernelStart      = kernel_q;
  assign singleVertex     = single_q;
  assign maskSourceSelect = maskSel_q;
  assign samplerPrefetch  = sampler_q;
  assign shaderStageOn    = shader_q;
  assign vertexReuseOff   = reuse_q;
  assign initMaskVector   = initMask_q;
  assign execMaskVector   = execMask_q;
  assign stateApplied     = applied_q;
  assign headerError      = hdrErr_q;
  assign shadeValid       = route_q[3];
  assign storeValid       = route_q[2];
  assign passValid        = route_q[1];
  assign hitValid         = route_q[0];
  assign vtxIndexOut      = vOut_q;

endmodule

`default_nettype wire

// ### vertex_state_feeder.sv
`timescale 1ns/1ps
`default_nettype none

module vertex_state_feeder
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  vertex_stage_if.host       link,
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire vss_pkg::dword_t avs_writedata,
  output vss_pkg::dword_t    avs_readdata,
  output logic               avs_waitrequest
);
  import vss_pkg::*;

  // ****************************************
  // Register slave
  // ****************************************
  dword_t      kernelReg_q, kernelReg_d;
  dword_t      dispReg_q, dispReg_d;
  logic [1:0]  ctrlReg_q, ctrlReg_d;
  logic        wait_q, wait_d;
  dword_t      rdata_q, rdata_d;
  logic        go;
  feed_state_t state_q, state_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        valid_q, valid_d;
  dword_t      data_q, data_d;
  logic        doWrite;

  // One wait cycle per access; the write lands on the released edge
  assign doWrite = avs_write && !wait_q;

  always_comb
  begin
    kernelReg_d = kernelReg_q;
    dispReg_d   = dispReg_q;
    ctrlReg_d   = ctrlReg_q;
    go          = 1'b0;
    wait_d      = !((avs_read || avs_write) && wait_q);
    rdata_d     = rdata_q;
    if (avs_read && wait_q)
    begin
      case (avs_address)
        REG_KERNEL:   rdata_d = kernelReg_q;
        REG_DISPATCH: rdata_d = dispReg_q;
        REG_CONTROL:  rdata_d = {30'h00000000, ctrlReg_q};
        REG_GO:       rdata_d = {31'h00000000, state_q == FEED_SEND};
        default:      rdata_d = 32'h00000000;
      endcase
    end
    if (doWrite)
    begin
      case (avs_address)
        REG_KERNEL:   kernelReg_d = avs_writedata & 32'hFFFFFFC0;
        REG_DISPATCH: dispReg_d   = avs_writedata & 32'hF8000000;
        REG_CONTROL:  ctrlReg_d   = avs_writedata[1:0];
        REG_GO:       go          = avs_writedata[GO_BIT];
        default:      go          = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Packet sender
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    valid_d = valid_q;
    data_d  = data_q;
    case (state_q)
      FEED_IDLE:
      begin
        if (go)
        begin
          state_d = FEED_SEND;
          cnt_d   = 3'h0;
          valid_d = 1'b1;
          data_d  = {PIPE_CMD_CLASS, PIPE_3D_SUB, PIPELINED_OP, VSTAGE_SUBOP,
                     8'h00, DEFAULT_LEN};
        end
      end
      FEED_SEND:
      begin
        if (valid_q && link.dwReady)
        begin
          cnt_d = cnt_q + 3'h1;
          case (cnt_q)
            3'h0:    data_d = kernelReg_q;
            3'h1:    data_d = dispReg_q;
            3'h4:    data_d = {30'h00000000, ctrlReg_q};
            default: data_d = 32'h00000000;
          endcase
          if (cnt_q == PKT_LAST)
          begin
            valid_d = 1'b0;
            state_d = FEED_IDLE;
          end
        end
      end
      default:
      begin
        state_d = FEED_IDLE;
        valid_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kernelReg_q <= 32'h00000000;
      dispReg_q   <= 32'h00000000;
      ctrlReg_q   <= 2'h0;
      wait_q      <= 1'b1;
      rdata_q     <= 32'h00000000;
      state_q     <= FEED_IDLE;
      cnt_q       <= 3'h0;
      valid_q     <= 1'b0;
      data_q      <= 32'h00000000;
    end
    else
    begin
      kernelReg_q <= kernelReg_d;
      dispReg_q   <= dispReg_d;
      ctrlReg_q   <= ctrlReg_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      valid_q     <= valid_d;
      data_q      <= data_d;
    end
  end

  assign link.dwValid    = valid_q;
  assign link.dwData     = data_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule

`default_nettype wire

// ### vertex_stage_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module vertex_stage_asserts
(
  input wire logic            clock,
  input wire logic            rst_n,
  input wire logic            dwValid,
  input wire vss_pkg::dword_t dwData,
  input wire logic            dwReady
);
  import vss_pkg::*;

  // ****************************************
  // Dword position inside the packet
  // ****************************************
  logic       take;
  logic [2:0] posQ;
  logic [2:0] posD;

  assign take = dwValid && dwReady;

  // Feeder always sends length 4, so six dwords make a packet
  always_comb
  begin
    posD = posQ;
    if (take)
      posD = (posQ == PKT_LAST) ? 3'h0 : posQ + 3'h1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      posQ <= 3'h0;
    else
      posQ <= posD;
  end

  // ****************************************
  // Link checks
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_ready_after_reset: assert property (rst_n && $past(rst_n) |-> dwReady)
    else $error("dword ready dropped outside reset");
  a_header_class: assert property (take && posQ == 3'h0 |->
    dwData[31:29] == 3'h3 && dwData[28:27] == 2'h3)
    else $error("header class or subclass wrong");
  a_header_opcode: assert property (take && posQ == 3'h0 |->
    dwData[26:24] == 3'h0 && dwData[23:16] == 8'h10 && dwData[15:8] == 8'h00)
    else $error("header opcode or sub-opcode wrong");
  a_header_length: assert property (take && posQ == 3'h0 |-> dwData[7:0] == 8'h04)
    else $error("header length field wrong");
  a_packet_span: assert property (take && posQ == 3'h0 |-> take [*6] ##1 !dwValid)
    else $error("packet not six consecutive dwords");
  a_kernel_low_zero: assert property (take && posQ == 3'h1 |-> dwData[5:0] == 6'h00)
    else $error("kernel dword low bits not zero");
  a_dispatch_fields: assert property (take && posQ == 3'h2 |->
    dwData[26:0] == 27'h0000000 && dwData[29:27] <= 3'h4)
    else $error("dispatch dword out of range");
  a_control_fields: assert property (take && posQ == PKT_LAST |->
    dwData[31:2] == 30'h00000000)
    else $error("control dword upper bits not zero");

  c_cached_shaded: cover property (take && posQ == PKT_LAST && dwData[1:0] == 2'h3);
  c_all_off: cover property (take && posQ == PKT_LAST && dwData[1:0] == 2'h0);
  c_max_samplers: cover property (take && posQ == 3'h2 && dwData[29:27] == 3'h4);
endmodule

`default_nettype wire

// ### tb_vertex_stage_state_decode.sv
`timescale 1ns/1ps
`default_nettype none

module tb_vertex_stage_state_decode;
  import vss_pkg::*;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        drawBoundary = 1'b0;
  logic        instanceBoundary = 1'b0;
  logic        oneFlowFlag = 1'b0;
  logic        vtxValid = 1'b0;
  vidx_t       vtxIndex = 16'h0000;
  logic [25:0] kernelStart;
  logic [2:0]  samplerPrefetch;
  logic        singleVertex, maskSourceSelect, shaderStageOn, vertexReuseOff;
  logic        initMaskVector, execMaskVector, stateApplied, headerError;
  logic        shadeValid, storeValid, passValid, hitValid;
  vidx_t       vtxIndexOut;
  logic [3:0]  avsAddress = 4'h0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  dword_t      avsWriteData = 32'h00000000;
  dword_t      avsReaddata;
  logic        avsWaitrequest;
  int          nMismatch = 0;
  int          nChecks = 0;
  int          nApplied = 0;

  always #50 clock = ~clock;

  vertex_stage_if vertex_stage_if_inst ();

  vertex_stage_decode vertex_stage_decode_inst
  (
    .clock(clock), .rst_n(rst_n), .link(vertex_stage_if_inst),
    .drawBoundary(drawBoundary), .instanceBoundary(instanceBoundary),
    .oneFlowFlag(oneFlowFlag), .vtxValid(vtxValid), .vtxIndex(vtxIndex),
    .kernelStart(kernelStart), .singleVertex(singleVertex),
    .maskSourceSelect(maskSourceSelect), .samplerPrefetch(samplerPrefetch),
    .shaderStageOn(shaderStageOn), .vertexReuseOff(vertexReuseOff),
    .initMaskVector(initMaskVector), .execMaskVector(execMaskVector),
    .stateApplied(stateApplied), .headerError(headerError), .shadeValid(shadeValid),
    .storeValid(storeValid), .passValid(passValid), .hitValid(hitValid),
    .vtxIndexOut(vtxIndexOut)
  );

  vertex_state_feeder vertex_state_feeder_inst
  (
    .clock(clock), .rst_n(rst_n), .link(vertex_stage_if_inst),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWriteData), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest)
  );

  vertex_stage_asserts vertex_stage_asserts_inst
  (
    .clock(clock), .rst_n(rst_n), .dwValid(vertex_stage_if_inst.dwValid),
    .dwData(vertex_stage_if_inst.dwData), .dwReady(vertex_stage_if_inst.dwReady)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
      nMismatch++;
    end
  endtask

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Extra edge at the end keeps strobes from being re-driven in one time step
  task automatic avAccess(input logic rd, input logic [3:0] a, input dword_t d,
                          output dword_t q);
    avsAddress <= a;
    avsWriteData <= d;
    avsRead <= rd;
    avsWrite <= !rd;
    // Only the watchdog ends a wait that never completes
    do
    begin
      @(posedge clock);
    end
    while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clock);
  endtask

  task automatic pulse(input logic inst);
    if (inst)
      instanceBoundary <= 1'b1;
    else
      drawBoundary <= 1'b1;
    @(posedge clock);
    instanceBoundary <= 1'b0;
    drawBoundary <= 1'b0;
    @(posedge clock);
  endtask

  // Expected code is {shade, store, pass, hit}
  task automatic vtx(input vidx_t idx, input logic [3:0] exp);
    vtxValid <= 1'b1;
    vtxIndex <= idx;
    @(posedge clock);
    vtxValid <= 1'b0;
    @(posedge clock);
    check("vertex route", 32'({shadeValid, storeValid, passValid, hitValid}), 32'(exp));
    check("vertex index", 32'(vtxIndexOut), 32'(idx));
  endtask

  // A second start while busy must not produce a second packet
  task automatic sendPacket(input dword_t k, input dword_t d, input dword_t c);
    int i;
    dword_t q;
    avAccess(1'b0, REG_KERNEL, k, q);
    avAccess(1'b0, REG_DISPATCH, d, q);
    avAccess(1'b0, REG_CONTROL, c, q);
    avAccess(1'b0, REG_GO, 32'h00000001, q);
    avAccess(1'b1, REG_GO, 32'h00000000, q);
    check("busy while sending", 32'(q[0]), 32'h00000001);
    avAccess(1'b0, REG_GO, 32'h00000001, q);
    i = 0;
    while (stateApplied !== 1'b1 && i < 40)
    begin
      @(posedge clock);
      i++;
    end
    check("headerError", 32'(headerError), 32'h00000000);
    avAccess(1'b1, REG_GO, 32'h00000000, q);
    check("busy after apply", 32'(q[0]), 32'h00000000);
  endtask

  always @(posedge clock)
    if (stateApplied === 1'b1)
      nApplied++;

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    logic [2:0] m;
    logic       s, r, f, sel;
    dword_t     k, d, q;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check("kernelStart reset", 32'(kernelStart), 32'h00000000);
    avAccess(1'b1, REG_CONTROL, 32'h00000000, q);
    check("control reset", q, 32'h00000000);
    avAccess(1'b1, 4'h2, 32'h00000000, q);
    check("unmapped read", q, 32'h00000000);
    avAccess(1'b0, REG_KERNEL, 32'hFFFFFFFF, q);
    avAccess(1'b1, REG_KERNEL, 32'h00000000, q);
    check("kernel readback", q, 32'hFFFFFFC0);
    avAccess(1'b0, REG_DISPATCH, 32'hFFFFFFFF, q);
    avAccess(1'b1, REG_DISPATCH, 32'h00000000, q);
    check("dispatch readback", q, 32'hF8000000);
    avAccess(1'b0, REG_CONTROL, 32'hFFFFFFFF, q);
    avAccess(1'b1, REG_CONTROL, 32'h00000000, q);
    check("control readback", q, 32'h00000003);
    for (int i = 0; i < 5; i++)
    begin
      m = 3'(i);
      r = m[1];
      s = m[0] | m[2];
      f = m[0];
      sel = m[1];
      k = 32'h12345640 ^ (32'(i) << 8);
      d = {m[0], sel, m, 27'h0000000};
      oneFlowFlag <= f;
      sendPacket(k, d, {30'h00000000, r, s});
      check("kernelStart", 32'(kernelStart), s ? 32'(k[31:6]) : 32'h00000000);
      check("samplerPrefetch", 32'(samplerPrefetch), s ? 32'(m) : 32'h00000000);
      check("dispatch bits", 32'({singleVertex, maskSourceSelect}), 32'({m[0], sel}));
      check("mode bits", 32'({vertexReuseOff, shaderStageOn}), 32'({r, s}));
      check("mask use", 32'({initMaskVector, execMaskVector}), 32'({!f & sel, f & sel}));
      pulse(1'b0);
      vtx(16'h0005 + 16'(i), {s, !s & r, !s, 1'b0});
      vtx(16'h0005 + 16'(i), {s & !r, 1'b0, !s, r});
      if (r)
      begin
        pulse(1'b1);
        vtx(16'h0005 + 16'(i), {s, !s, !s, 1'b0});
      end
    end
    // Cache survives a packet unless a mode change invalidates it
    sendPacket(32'h00000040, 32'h00000000, 32'h00000003);
    vtx(16'h0020, 4'b1000);
    sendPacket(32'h00000040, 32'h00000000, 32'h00000002);
    vtx(16'h0020, 4'b0110);
    sendPacket(32'h00000040, 32'h00000000, 32'h00000000);
    sendPacket(32'h00000040, 32'h00000000, 32'h00000002);
    vtx(16'h0020, 4'b0110);
    vtx(16'h0020, 4'b0011);
    check("packets applied", 32'(nApplied), 32'h00000009);
    wrapUp;
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    nMismatch++;
    wrapUp;
  end
endmodule

`default_nettype wire
